// file: src/sdcr_regs.v
`timescale 1ns/100ps
`include "sdcr_consts.vh"


module sdcr_regs
(
    input  wire       ref_clk_in,
    input  wire       rst_in,
    input  wire       bus_chip_select_in,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe_out,
    input  wire       general_output_value_in,
    input  wire       signal_detect_in,
    input  wire       pin0_in,
    output wire       pin0_out,
    output wire       pin0_oe_out,
    output wire       pullup_en_out,
    output wire       pulldown_en_out,
    output wire       pin0_value_out,
    output wire       soft_reset_out
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam [3:0] ST_IDLE     = 4'h0;
localparam [3:0] ST_ADDR     = 4'h1;
localparam [3:0] ST_ADDR_ACK = 4'h2;
localparam [3:0] ST_REG      = 4'h3;
localparam [3:0] ST_REG_ACK  = 4'h4;
localparam [3:0] ST_WDATA    = 4'h5;
localparam [3:0] ST_WR_ACK   = 4'h6;
localparam [3:0] ST_RDATA    = 4'h7;
localparam [3:0] ST_RD_ACK   = 4'h8;

// ----------------------------------------------------------------
// storage
// ----------------------------------------------------------------
reg  [6:0] bus_address_field;
reg        soft_reset_request;
reg  [3:0] pin0_mode;
reg  [1:0] pin0_pull;
reg        pin0_in_buf_en;
reg        pin0_out_en;

reg  [3:0] state;
reg  [7:0] shift;
reg  [3:0] bit_cnt;
reg  [7:0] pointer;
reg        read_more;
reg        scl_prev;
reg        sda_prev;

wire       cfg_reset;
wire       scl_rise;
wire       scl_fall;
wire       bus_start;
wire       bus_stop;
wire       wr_strobe;
wire [7:0] rd_byte;

// ----------------------------------------------------------------
// read decode
// ----------------------------------------------------------------
// unmapped offsets read zero; reserved bits read zero
function [7:0] sdcr_read;
    input [7:0] off;
    input [6:0] addr;
    input       srst;
    input [3:0] mode;
    input [1:0] pull;
    input       inbuf;
    input       outen;
    begin
        case (off)
            `SDCR_OFF_ADDR: sdcr_read = {addr, 1'b0};
            `SDCR_OFF_SRST: sdcr_read = {7'h00, srst};
            `SDCR_OFF_PIN0: sdcr_read = {mode, pull, inbuf, outen};
            default:        sdcr_read = 8'h00;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// bus line events
// ----------------------------------------------------------------
// pins are synchronous, so one stage of history is enough for edges
always @(posedge ref_clk_in)
begin
    if (rst_in)
    begin
        scl_prev <= 1'b1;
        sda_prev <= 1'b1;
    end
    else
    begin
        scl_prev <= scl_in;
        sda_prev <= sda_in;
    end
end

assign scl_rise  = scl_in & ~scl_prev;
assign scl_fall  = ~scl_in & scl_prev;
assign bus_start = scl_in & scl_prev & sda_prev & ~sda_in;
assign bus_stop  = scl_in & scl_prev & ~sda_prev & sda_in;
assign sda_out   = 1'b0;                  // open drain: only pulls low

// a data byte completes on the falling clock after its eighth bit
assign wr_strobe = (state == ST_WDATA) & scl_fall & (bit_cnt == `SDCR_BITS_PER_BYTE);

// byte at the pointer; one decode serves the first and every later read byte
assign rd_byte = sdcr_read(pointer, bus_address_field, soft_reset_request, pin0_mode,
                           pin0_pull, pin0_in_buf_en, pin0_out_en);

// ----------------------------------------------------------------
// serial slave state machine
// ----------------------------------------------------------------
// soft reset leaves the bus engine alone so the acknowledge of the
// write that asked for it still completes cleanly
always @(posedge ref_clk_in)
begin
    if (rst_in)
    begin
        state      <= ST_IDLE;
        shift      <= 8'h00;
        bit_cnt    <= 4'h0;
        pointer    <= 8'h00;
        read_more  <= 1'b0;
        sda_oe_out <= 1'b0;
    end
    else if (bus_start)
    begin
        state      <= ST_ADDR;
        bit_cnt    <= 4'h0;
        sda_oe_out <= 1'b0;
    end
    else if (bus_stop)
    begin
        state      <= ST_IDLE;
        sda_oe_out <= 1'b0;
    end
    else
    begin
        case (state)
            ST_IDLE:
            begin
                sda_oe_out <= 1'b0;
            end
            ST_ADDR, ST_REG, ST_WDATA:
            begin
                if (scl_rise)
                begin
                    shift   <= {shift[6:0], sda_in};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                else if (scl_fall && bit_cnt == `SDCR_BITS_PER_BYTE)
                begin
                    bit_cnt <= 4'h0;
                    if (state == ST_ADDR)
                    begin
                        // address sits one place left; low bit is direction
                        if (shift[7:1] == bus_address_field
                            && bus_chip_select_in)
                        begin
                            read_more  <= shift[0];
                            sda_oe_out <= 1'b1;
                            state      <= ST_ADDR_ACK;
                        end
                        else
                        begin
                            state <= ST_IDLE;
                        end
                    end
                    else if (state == ST_REG)
                    begin
                        pointer    <= shift;
                        sda_oe_out <= 1'b1;
                        state      <= ST_REG_ACK;
                    end
                    else
                    begin
                        pointer    <= pointer + 8'h01;
                        sda_oe_out <= 1'b1;
                        state      <= ST_WR_ACK;
                    end
                end
            end
            ST_ADDR_ACK:
            begin
                if (scl_fall)
                begin
                    if (read_more)
                    begin
                        shift      <= rd_byte;
                        sda_oe_out <= ~rd_byte[7];  // msb goes out first
                        state      <= ST_RDATA;
                    end
                    else
                    begin
                        sda_oe_out <= 1'b0;
                        state      <= ST_REG;
                    end
                end
            end
            ST_REG_ACK, ST_WR_ACK:
            begin
                if (scl_fall)
                begin
                    sda_oe_out <= 1'b0;
                    state      <= ST_WDATA;
                end
            end
            ST_RDATA:
            begin
                if (scl_fall)
                begin
                    if (bit_cnt == 4'h7)
                    begin
                        sda_oe_out <= 1'b0;  // release for master acknowledge
                        pointer    <= pointer + 8'h01;
                        bit_cnt    <= 4'h0;
                        state      <= ST_RD_ACK;
                    end
                    else
                    begin
                        shift      <= {shift[6:0], 1'b0};
                        sda_oe_out <= ~shift[6];
                        bit_cnt    <= bit_cnt + 4'h1;
                    end
                end
            end
            ST_RD_ACK:
            begin
                if (scl_rise)
                begin
                    read_more <= ~sda_in;
                end
                else if (scl_fall)
                begin
                    if (read_more)
                    begin
                        shift      <= rd_byte;
                        sda_oe_out <= ~rd_byte[7];
                        state      <= ST_RDATA;
                    end
                    else
                    begin
                        state <= ST_IDLE;
                    end
                end
            end
            default:
            begin
                state      <= ST_IDLE;
                sda_oe_out <= 1'b0;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// bus address register
// ----------------------------------------------------------------
// only power-up reset touches it; the soft reset must not move the slave
always @(posedge ref_clk_in)
begin
    if (rst_in)
        bus_address_field <= `SDCR_ADDR_RST;
    else if (wr_strobe && pointer == `SDCR_OFF_ADDR)
        bus_address_field <= shift[`SDCR_ADDR_MSB:`SDCR_ADDR_LSB];
end

// ----------------------------------------------------------------
// soft reset and pin configuration registers
// ----------------------------------------------------------------
// the request lives one clock, then its own reset clears it
assign cfg_reset      = rst_in | soft_reset_request;
assign soft_reset_out = soft_reset_request;

always @(posedge ref_clk_in)
begin
    if (cfg_reset)
    begin
        soft_reset_request <= 1'b0;
        pin0_mode          <= `SDCR_MODE_RST;
        pin0_pull          <= `SDCR_PULL_RST;
        pin0_in_buf_en     <= `SDCR_INBUF_RST;
        pin0_out_en        <= `SDCR_OUTEN_RST;
    end
    else if (wr_strobe)
    begin
        if (pointer == `SDCR_OFF_SRST)
            soft_reset_request <= shift[`SDCR_SRST_BIT];
        if (pointer == `SDCR_OFF_PIN0)
        begin
            pin0_mode      <= shift[`SDCR_MODE_MSB:`SDCR_MODE_LSB];
            pin0_pull      <= shift[`SDCR_PULL_MSB:`SDCR_PULL_LSB];
            pin0_in_buf_en <= shift[`SDCR_INBUF_BIT];
            pin0_out_en    <= shift[`SDCR_OUTEN_BIT];
        end
    end
end

// ----------------------------------------------------------------
// pin 0 driver
// ----------------------------------------------------------------
sdcr_pin0_ctrl u_pin0
(
    .ref_clk_in              (ref_clk_in),
    .rst_in                  (cfg_reset),
    .mode_in                 (pin0_mode),
    .pull_in                 (pin0_pull),
    .in_buf_en_in            (pin0_in_buf_en),
    .out_en_in               (pin0_out_en),
    .general_output_value_in (general_output_value_in),
    .signal_detect_in        (signal_detect_in),
    .pin0_in                 (pin0_in),
    .pin0_out                (pin0_out),
    .pin0_oe_out             (pin0_oe_out),
    .pullup_en_out           (pullup_en_out),
    .pulldown_en_out         (pulldown_en_out),
    .pin0_value_out          (pin0_value_out)
);

endmodule // sdcr_regs

// file: inc/sdcr_consts.vh
`ifndef SDCR_CONSTS_VH
`define SDCR_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SDCR_OFF_ADDR       8'h00
`define SDCR_OFF_SRST       8'h01
`define SDCR_OFF_PIN0       8'h02

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SDCR_ADDR_MSB       7
`define SDCR_ADDR_LSB       1
`define SDCR_SRST_BIT       0
`define SDCR_MODE_MSB       7
`define SDCR_MODE_LSB       4
`define SDCR_PULL_MSB       3
`define SDCR_PULL_LSB       2
`define SDCR_INBUF_BIT      1
`define SDCR_OUTEN_BIT      0

// ----------------------------------------------------------------
// reset values (bus address value is arbitrary)
// ----------------------------------------------------------------
`define SDCR_ADDR_RST       7'h2A
`define SDCR_MODE_RST       4'h0
`define SDCR_PULL_RST       2'h1
`define SDCR_INBUF_RST      1'h0
`define SDCR_OUTEN_RST      1'h1

// ----------------------------------------------------------------
// field codes
// ----------------------------------------------------------------
`define SDCR_MODE_GENERAL_OUTPUT_VALUE     4'h0
`define SDCR_MODE_SIGDET    4'h1
`define SDCR_PULL_NONE      2'h0
`define SDCR_PULL_DOWN      2'h1
`define SDCR_PULL_UP        2'h2

// ----------------------------------------------------------------
// protocol counts
// ----------------------------------------------------------------
`define SDCR_BITS_PER_BYTE  4'h8

`endif

// file: src/sdcr_pin0_ctrl.v
`timescale 1ns/100ps
`include "sdcr_consts.vh"

module sdcr_pin0_ctrl
(
    input  wire       ref_clk_in,
    input  wire       rst_in,
    input  wire [3:0] mode_in,
    input  wire [1:0] pull_in,
    input  wire       in_buf_en_in,
    input  wire       out_en_in,
    input  wire       general_output_value_in,
    input  wire       signal_detect_in,
    input  wire       pin0_in,
    output reg        pin0_out,
    output reg        pin0_oe_out,
    output reg        pullup_en_out,
    output reg        pulldown_en_out,
    output reg        pin0_value_out
);

// ----------------------------------------------------------------
// function decode
// ----------------------------------------------------------------
// reserved codes drive low so an undefined selection never floats data
function sdcr_pin_src;
    input [3:0] mode;
    input       general_output_value;
    input       sigdet;
    begin
        case (mode)
            `SDCR_MODE_GENERAL_OUTPUT_VALUE:  sdcr_pin_src = general_output_value;
            `SDCR_MODE_SIGDET: sdcr_pin_src = sigdet;
            default:           sdcr_pin_src = 1'b0;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// registered pin drive
// ----------------------------------------------------------------
// pin value, enable and pulls follow the configuration one clock later
always @(posedge ref_clk_in)
begin
    if (rst_in)
    begin
        pin0_out        <= 1'b0;
        pin0_oe_out     <= 1'b0;
        pullup_en_out   <= 1'b0;
        pulldown_en_out <= 1'b0;
        pin0_value_out  <= 1'b0;
    end
    else
    begin
        pin0_out        <= sdcr_pin_src(mode_in, general_output_value_in,
                                        signal_detect_in);
        pin0_oe_out     <= out_en_in;
        pullup_en_out   <= (pull_in == `SDCR_PULL_UP);
        pulldown_en_out <= (pull_in == `SDCR_PULL_DOWN);
        pin0_value_out  <= in_buf_en_in & pin0_in;         // buffer off reads 0
    end
end

endmodule // sdcr_pin0_ctrl

// file: test/sdcr_regs_monitor.sv
`timescale 1ns/100ps

module sdcr_regs_monitor
(
    input wire ref_clk_in,
    input wire rst_in,
    input wire bus_chip_select_in,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_out,
    input wire general_output_value_in,
    input wire signal_detect_in,
    input wire pin0_in,
    input wire pin0_out,
    input wire pin0_oe_out,
    input wire pullup_en_out,
    input wire pulldown_en_out,
    input wire pin0_value_out,
    input wire soft_reset_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    // ----------------------------------------------------------------
    // bus timing
    // ----------------------------------------------------------------
    sequence s_oe_hold;
        sda_oe_out [*3];
    endsequence
    sequence s_pin_dflt;
        pin0_oe_out && pulldown_en_out && !pullup_en_out;
    endsequence
    // the device may only let go of SDA while SCL is low, else a false stop
    property p_oe_release;
        $fell(sda_oe_out) |-> !scl_in;
    endproperty
    property p_ack_hold;
        $rose(sda_oe_out) |-> !scl_in ##1 s_oe_hold;
    endproperty

    // ----------------------------------------------------------------
    // register effects
    // ----------------------------------------------------------------
    property p_pull_excl;
        !(pullup_en_out && pulldown_en_out);
    endproperty
    property p_reset_dflt;
        $fell(rst_in) |-> ##[0:2] s_pin_dflt;
    endproperty
    property p_srst_pulse;
        soft_reset_out |=> !soft_reset_out;
    endproperty
    property p_srst_dflt;
        soft_reset_out |-> ##[1:3] s_pin_dflt;
    endproperty
    property p_srst_ack;
        soft_reset_out |-> ##[0:2] sda_oe_out;
    endproperty
    property p_pin_src;
        pin0_out |-> ($past(general_output_value_in) || $past(signal_detect_in));
    endproperty
    property p_value_gate;
        pin0_value_out |-> $past(pin0_in);
    endproperty

    a_oe_release: assert property (p_oe_release)
        else $error("sda released while scl high");
    a_ack_hold: assert property (p_ack_hold)
        else $error("sda low too short");
    a_pull_excl: assert property (p_pull_excl)
        else $error("both pulls on");
    a_reset_dflt: assert property (p_reset_dflt)
        else $error("pin defaults missing");
    a_srst_pulse: assert property (p_srst_pulse)
        else $error("soft reset not a pulse");
    a_srst_dflt: assert property (p_srst_dflt)
        else $error("soft reset left config");
    a_srst_ack: assert property (p_srst_ack)
        else $error("soft reset broke ack");
    a_pin_src: assert property (p_pin_src)
        else $error("pin high with no source");
    a_value_gate: assert property (p_value_gate)
        else $error("pin value without input");
endmodule // sdcr_regs_monitor

bind sdcr_regs sdcr_regs_monitor u_mon (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .bus_chip_select_in(bus_chip_select_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .general_output_value_in(general_output_value_in),
    .signal_detect_in(signal_detect_in), .pin0_in(pin0_in), .pin0_out(pin0_out),
    .pin0_oe_out(pin0_oe_out), .pullup_en_out(pullup_en_out),
    .pulldown_en_out(pulldown_en_out), .pin0_value_out(pin0_value_out),
    .soft_reset_out(soft_reset_out));

// file: test/sdcr_host_model.sv
`timescale 1ns/100ps

module sdcr_host_model
(
    input  wire ref_clk_in,
    input  wire sda_in,
    output reg  scl_out,
    output reg  sda_pull_out
);
    // bus idles with both lines released; scl stands still between frames
    initial
    begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end

    // four clocks per phase keeps well above the two-clock edge spacing
    task step(input s, input p);
    begin
        repeat (4) @(posedge ref_clk_in);
        scl_out <= s;
        sda_pull_out <= p;
    end
    endtask

    task bit_cycle(input p, output v);
    begin
        step(1'b0, p);
        step(1'b1, p);
        repeat (2) @(posedge ref_clk_in);
        v = sda_in;
        step(1'b0, p);
    end
    endtask

    // also serves as repeated start after an acknowledge
    task start;
    begin
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    end
    endtask

    task stop;
    begin
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    end
    endtask

    // msb first; a read sends all ones so the line is left to the device
    task xfer(input [7:0] tx, input mack, output [7:0] rxd, output ack);
        integer k;
        reg     v;
    begin
        for (k = 7; k >= 0; k = k - 1)
        begin
            bit_cycle(~tx[k], v);
            rxd[k] = v;
        end
        bit_cycle(mack, v);
        ack = ~v;
    end
    endtask
endmodule // sdcr_host_model

// file: test/sdcr_regs_tb.sv
`timescale 1ns/100ps
`include "sdcr_consts.vh"

module sdcr_regs_tb;
    reg        ref_clk_in;
    reg        rst_in;
    reg        bus_chip_select_in;
    reg        general_output_value_in;
    reg        signal_detect_in;
    reg        pin0_in;
    wire       scl;
    wire       host_pull;
    wire       sda_wire;
    wire       sda_out;
    wire       sda_oe_out;
    wire       pin0_out;
    wire       pin0_oe_out;
    wire       pullup_en_out;
    wire       pulldown_en_out;
    wire       pin0_value_out;
    wire       soft_reset_out;
    integer    bad_count;
    integer    num_checks;
    integer    srst_seen = 0;
    integer    i;
    reg  [7:0] rx;
    reg  [6:0] a;

    // pulled-up open-drain data line
    assign sda_wire = (sda_oe_out ? sda_out : 1'b1) & ~host_pull;

    initial
    begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    sdcr_host_model u_host (.ref_clk_in(ref_clk_in), .sda_in(sda_wire),
        .scl_out(scl), .sda_pull_out(host_pull));

    sdcr_regs u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .bus_chip_select_in(bus_chip_select_in), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .general_output_value_in(general_output_value_in),
        .signal_detect_in(signal_detect_in), .pin0_in(pin0_in), .pin0_out(pin0_out),
        .pin0_oe_out(pin0_oe_out), .pullup_en_out(pullup_en_out),
        .pulldown_en_out(pulldown_en_out), .pin0_value_out(pin0_value_out),
        .soft_reset_out(soft_reset_out));

    always @(posedge ref_clk_in)
        if (soft_reset_out === 1'b1)
            srst_seen <= srst_seen + 1;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task check(input [8*10-1:0] name, input [7:0] seen, input [7:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
        end
    end
    endtask

    task report_and_stop;
    begin
        if (bad_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    // address byte is the seven-bit address shifted up one place
    task wr(input [6:0] ad, input [7:0] o, input [7:0] d, input exp_ack);
        reg ak;
    begin
        u_host.start();
        u_host.xfer({ad, 1'b0}, 1'b0, rx, ak);
        check("addr_ack", {7'h00, ak}, {7'h00, exp_ack});
        if (ak)
        begin
            u_host.xfer(o, 1'b0, rx, ak);
            u_host.xfer(d, 1'b0, rx, ak);
            check("data_ack", {7'h00, ak}, 8'h01);
        end
        u_host.stop();
    end
    endtask

    task rd(input [6:0] ad, input [7:0] o, input [7:0] exp, input [8*10-1:0] name);
        reg ak;
    begin
        u_host.start();
        u_host.xfer({ad, 1'b0}, 1'b0, rx, ak);
        u_host.xfer(o, 1'b0, rx, ak);
        u_host.start();
        u_host.xfer({ad, 1'b1}, 1'b0, rx, ak);
        u_host.xfer(8'hFF, 1'b0, rx, ak);
        u_host.stop();
        check(name, rx, exp);
    end
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        bad_count = 0;
        num_checks = 0;
        a = `SDCR_ADDR_RST;
        rst_in = 1'b1;
        bus_chip_select_in = 1'b1;
        general_output_value_in = 1'b0;
        signal_detect_in = 1'b0;
        pin0_in = 1'b1;
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        rd(a, `SDCR_OFF_ADDR, {a, 1'b0}, "addr_dflt");
        rd(a, `SDCR_OFF_SRST, 8'h00, "srst_dflt");
        rd(a, `SDCR_OFF_PIN0, 8'h05, "pin0_dflt");
        rd(a, 8'h07, 8'h00, "unmapped");
        wr(a + 7'h01, `SDCR_OFF_PIN0, 8'h00, 1'b0);
        bus_chip_select_in <= 1'b0;
        wr(a, `SDCR_OFF_PIN0, 8'h00, 1'b0);
        bus_chip_select_in <= 1'b1;
        wr(a, 8'h07, 8'hAA, 1'b1);
        rd(a, `SDCR_OFF_PIN0, 8'h05, "pin0_kept");
        // reserved pull code 11 is never written
        for (i = 0; i < 3; i = i + 1)
        begin
            wr(a, `SDCR_OFF_PIN0, {4'h0, i[1:0], 2'b01}, 1'b1);
            check("pullup", {7'h00, pullup_en_out}, {7'h00, i == 2});
            check("pulldown", {7'h00, pulldown_en_out}, {7'h00, i == 1});
        end
        // the unused source is held opposite, so a wrong pick shows
        for (i = 0; i < 4; i = i + 1)
        begin
            if (i[0] == 1'b0)
                wr(a, `SDCR_OFF_PIN0, {3'h0, i[1], 4'h1}, 1'b1);
            general_output_value_in <= i[1] ? ~i[0] : i[0];
            signal_detect_in <= i[1] ? i[0] : ~i[0];
            repeat (4) @(posedge ref_clk_in);
            check("pin_out", {7'h00, pin0_out}, {7'h00, i[0]});
        end
        check("in_gated", {7'h00, pin0_value_out}, 8'h00);
        wr(a, `SDCR_OFF_PIN0, 8'h06, 1'b1);
        check("in_value", {7'h00, pin0_value_out}, 8'h01);
        check("out_en", {7'h00, pin0_oe_out}, 8'h00);
        wr(a, `SDCR_OFF_ADDR, 8'h60, 1'b1);
        wr(a, `SDCR_OFF_PIN0, 8'h00, 1'b0);
        a = 7'h30;
        rd(a, `SDCR_OFF_ADDR, 8'h60, "addr_new");
        wr(a, `SDCR_OFF_PIN0, 8'h1A, 1'b1);
        wr(a, `SDCR_OFF_SRST, 8'h01, 1'b1);
        check("srst_once", srst_seen[7:0], 8'h01);
        rd(a, `SDCR_OFF_PIN0, 8'h05, "pin0_srst");
        rd(a, `SDCR_OFF_SRST, 8'h00, "srst_clr");
        rd(a, `SDCR_OFF_ADDR, 8'h60, "addr_srst");
        report_and_stop();
    end

    // whole sequence needs roughly 9500 clocks
    initial
    begin
        repeat (60000) @(posedge ref_clk_in);
        bad_count = bad_count + 1;
        report_and_stop();
    end
endmodule // sdcr_regs_tb
